/* icm_regs.svh */
// register offsets, field positions and timing counts of the input clock block
`ifndef ICM_REGS_SVH
`define ICM_REGS_SVH

`define ICM_ADDR_W          10
`define ICM_OFF_XTAL_CFG    10'h300
`define ICM_OFF_AMP_DRIVE   10'h301
`define ICM_OFF_PIN_CAPS    10'h302
`define ICM_OFF_REF1_CFG    10'h303
`define ICM_OFF_REF2_CFG    10'h304
`define ICM_OFF_REF3_CFG    10'h305
`define ICM_OFF_STATUS      10'h306
`define ICM_RESET_VAL       8'h00
`define ICM_ZERO8           8'h00

`define ICM_BIT_POL         6
`define ICM_BIT_DIS         5
`define ICM_VT_HI           4
`define ICM_VT_LO           2
`define ICM_DIV_HI          1
`define ICM_DIV_LO          0
`define ICM_CAP2_HI         7
`define ICM_CAP2_LO         4
`define ICM_CAP1_HI         3
`define ICM_CAP1_LO         0

`define ICM_VT_1            3'h0
`define ICM_VT_4            3'h1
`define ICM_VT_16           3'h2
`define ICM_VT_64           3'h3
`define ICM_VT_256          3'h4
`define ICM_VT_1024         3'h5
`define ICM_DIV_1           2'h0
`define ICM_DIV_2           2'h1
`define ICM_DIV_4           2'h2
`define ICM_DIV_8           2'h3
`define ICM_VT_CNT_1        11'h001
`define ICM_VT_CNT_4        11'h004
`define ICM_VT_CNT_16       11'h010
`define ICM_VT_CNT_64       11'h040
`define ICM_VT_CNT_256      11'h100
`define ICM_VT_CNT_1024     11'h400
`define ICM_HL_DIV_2        3'h0
`define ICM_HL_DIV_4        3'h1
`define ICM_HL_DIV_8        3'h3

`define ICM_CNT_W           11
`define ICM_GAP_W           8
`define ICM_MISS_LIMIT      8'h40
`define ICM_NUM_IN          4
`define ICM_XTAL_IDX        0

`endif

/* icm_pkg.sv */
// types of the input clock configuration and monitor block
`default_nettype none
package icm_pkg;

  typedef enum logic [1:0] {
    ICM_MON_IDLE  = 2'b00,
    ICM_MON_CHECK = 2'b01,
    ICM_MON_VALID = 2'b11
  } icm_mon_st_t;

  typedef struct packed {
    icm_mon_st_t  st;
    logic [10:0]  vcnt;
    logic [7:0]   gap;
    logic         sig_d;
    logic [2:0]   dcnt;
    logic         dout;
    logic         feed;
    logic         pll;
    logic         valid;
  } icm_path_state_t;

  typedef struct packed {
    logic [6:0]   xtal_cfg;
    logic [7:0]   amp;
    logic [7:0]   caps;
    logic [6:0]   ref1_cfg;
    logic [6:0]   ref2_cfg;
    logic [6:0]   ref3_cfg;
    logic [7:0]   rdata;
    logic         conflict;
  } icm_top_state_t;

endpackage
`default_nettype wire

/* icm_path_if.sv */
// carrier between the register core and one input path
`timescale 1ns/100ps
`default_nettype none
interface icm_path_if;
  logic       lock_edge_select;
  logic       dis;
  logic [2:0] vtime;
  logic [1:0] div;
  logic       feed;
  logic       pll;
  logic       valid;

  modport ctl  (output lock_edge_select, output dis, output vtime, output div,
                input feed, input pll, input valid);
  modport path (input lock_edge_select, input dis, input vtime, input div,
                output feed, output pll, output valid);
endinterface
`default_nettype wire

/* icm_input_path.sv */
// one input path: monitor gate, validation monitor, pre-divider, edge select
`timescale 1ns/100ps
`default_nettype none
`include "icm_regs.svh"
module icm_input_path #(
  parameter bit XTAL = 1'b0
) (
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  sig,
  icm_path_if.path   cfg
);

  icm_pkg::icm_path_state_t q_r;
  icm_pkg::icm_path_state_t q_nxt;

  logic [10:0] target;
  logic [2:0]  hlast;
  logic        rise;
  logic        missing;
  logic        div_one;

  always_comb
  begin
    q_nxt   = q_r;
    target  = `ICM_VT_CNT_1024;
    hlast   = `ICM_HL_DIV_2;
    rise    = sig & ~q_r.sig_d;
    missing = 1'b0;
    div_one = 1'b0;
    q_nxt.sig_d = sig;
    case (cfg.vtime)
      `ICM_VT_1:   target = `ICM_VT_CNT_1;
      `ICM_VT_4:   target = `ICM_VT_CNT_4;
      `ICM_VT_16:  target = `ICM_VT_CNT_16;
      `ICM_VT_64:  target = `ICM_VT_CNT_64;
      `ICM_VT_256: target = `ICM_VT_CNT_256;
      default:     target = `ICM_VT_CNT_1024;
    endcase
    // monitor only sees the input while the feed is on
    q_nxt.feed = sig & ~cfg.dis;
    if (cfg.dis)
    begin
      q_nxt.st    = icm_pkg::ICM_MON_IDLE;
      q_nxt.vcnt  = '0;
      q_nxt.gap   = '0;
      q_nxt.valid = 1'b0;
    end
    else
    begin
      if (rise)
        q_nxt.gap = '0;
      else if (q_r.gap != `ICM_MISS_LIMIT)
        q_nxt.gap = q_r.gap + 8'h01;
      missing = (q_r.gap == `ICM_MISS_LIMIT) && !rise;
      case (q_r.st)
        icm_pkg::ICM_MON_IDLE:
        begin
          q_nxt.st   = icm_pkg::ICM_MON_CHECK;
          q_nxt.vcnt = '0;
        end
        icm_pkg::ICM_MON_CHECK:
        begin
          if (missing)
            q_nxt.vcnt = '0;
          else if (rise)
          begin
            if (q_r.vcnt + 11'h001 == target)
            begin
              q_nxt.st    = icm_pkg::ICM_MON_VALID;
              q_nxt.valid = 1'b1;
              q_nxt.vcnt  = '0;
            end
            else
              q_nxt.vcnt = q_r.vcnt + 11'h001;
          end
        end
        icm_pkg::ICM_MON_VALID:
        begin
          if (missing)
          begin
            q_nxt.st    = icm_pkg::ICM_MON_CHECK;
            q_nxt.vcnt  = '0;
            q_nxt.valid = 1'b0;
          end
        end
        default:
        begin
          q_nxt.st    = icm_pkg::ICM_MON_IDLE;
          q_nxt.valid = 1'b0;
        end
      endcase
    end
    // pre-divider: toggle every 2^(code-1) input rising edges; code 0, and codes 2 and 3 on the crystal, pass the input through
    case (cfg.div)
      `ICM_DIV_2: hlast = `ICM_HL_DIV_2;
      `ICM_DIV_4: hlast = XTAL ? `ICM_HL_DIV_2 : `ICM_HL_DIV_4;
      `ICM_DIV_8: hlast = XTAL ? `ICM_HL_DIV_2 : `ICM_HL_DIV_8;
      default:    hlast = `ICM_HL_DIV_2;
    endcase
    div_one = (cfg.div == `ICM_DIV_1) ||
              (XTAL && cfg.div[`ICM_DIV_HI]);
    if (div_one)
    begin
      q_nxt.dout = sig;
      q_nxt.dcnt = '0;
    end
    else if (rise)
    begin
      if (q_r.dcnt >= hlast)
      begin
        q_nxt.dcnt = '0;
        q_nxt.dout = ~q_r.dout;
      end
      else
        q_nxt.dcnt = q_r.dcnt + 3'h1;
    end
    // inverted feed makes the pll lock to the falling edge
    q_nxt.pll = q_nxt.dout ^ cfg.lock_edge_select;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign cfg.feed  = q_r.feed;
  assign cfg.pll   = q_r.pll;
  assign cfg.valid = q_r.valid;

  a_dis_no_valid: assert property (
    @(posedge clock) disable iff (!nrst)
    cfg.dis |=> !cfg.valid && !cfg.feed)
    else $error("valid or feed while monitor feed disabled");
  a_miss_drops: assert property (
    @(posedge clock) disable iff (!nrst)
    (!cfg.dis && q_r.gap == `ICM_MISS_LIMIT && !rise) |=> !cfg.valid)
    else $error("valid kept after missing edge");

endmodule // icm_input_path
`default_nettype wire

/* icm_top.sv */
// input clock configuration registers and the four input paths
`timescale 1ns/100ps
`default_nettype none
`include "icm_regs.svh"
module icm_top (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [9:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        doubler_enable,
  input  wire logic        crystal_input,
  input  wire logic        reference_input_1,
  input  wire logic        reference_input_2,
  input  wire logic        reference_input_3,
  output logic      [7:0]  crystal_amp_drive,
  output logic      [3:0]  second_pin_cap_sel,
  output logic      [3:0]  first_pin_cap_sel,
  output logic      [3:0]  monitor_feed,
  output logic      [3:0]  analog_pll_feed,
  output logic      [3:0]  input_valid,
  output logic             prediv_conflict
);

  icm_pkg::icm_top_state_t q_r;
  icm_pkg::icm_top_state_t q_nxt;

  logic [3:0]  sig_in;
  logic [6:0]  path_cfg [4];
  logic [3:0]  feed_w;
  logic [3:0]  pll_w;
  logic [3:0]  valid_w;

  icm_path_if pif [4] ();

  assign sig_in = {reference_input_3, reference_input_2,
                   reference_input_1, crystal_input};

  assign path_cfg[0] = q_r.xtal_cfg;
  assign path_cfg[1] = q_r.ref1_cfg;
  assign path_cfg[2] = q_r.ref2_cfg;
  assign path_cfg[3] = q_r.ref3_cfg;

  genvar gi;
  generate
    for (gi = 0; gi < `ICM_NUM_IN; gi = gi + 1)
    begin : g_path
      assign pif[gi].lock_edge_select   = path_cfg[gi][`ICM_BIT_POL];
      assign pif[gi].dis   = path_cfg[gi][`ICM_BIT_DIS];
      assign pif[gi].vtime = path_cfg[gi][`ICM_VT_HI:`ICM_VT_LO];
      assign pif[gi].div   = path_cfg[gi][`ICM_DIV_HI:`ICM_DIV_LO];
      assign feed_w[gi]    = pif[gi].feed;
      assign pll_w[gi]     = pif[gi].pll;
      assign valid_w[gi]   = pif[gi].valid;

      icm_input_path #(
        .XTAL (gi == `ICM_XTAL_IDX)
      ) u_path (
        .clock (clock),
        .nrst  (nrst),
        .sig   (sig_in[gi]),
        .cfg   (pif[gi])
      );
    end
  endgenerate

  always_comb
  begin
    q_nxt = q_r;
    if (reg_wr)
    begin
      case (reg_addr)
        `ICM_OFF_XTAL_CFG: q_nxt.xtal_cfg = reg_wdata[6:0];
        `ICM_OFF_AMP_DRIVE: q_nxt.amp     = reg_wdata;
        `ICM_OFF_PIN_CAPS:  q_nxt.caps    = reg_wdata;
        `ICM_OFF_REF1_CFG: q_nxt.ref1_cfg = reg_wdata[6:0];
        `ICM_OFF_REF2_CFG: q_nxt.ref2_cfg = reg_wdata[6:0];
        `ICM_OFF_REF3_CFG: q_nxt.ref3_cfg = reg_wdata[6:0];
        default:           q_nxt.rdata    = q_r.rdata;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `ICM_OFF_XTAL_CFG:  q_nxt.rdata = {1'b0, q_r.xtal_cfg};
        `ICM_OFF_AMP_DRIVE: q_nxt.rdata = q_r.amp;
        `ICM_OFF_PIN_CAPS:  q_nxt.rdata = q_r.caps;
        `ICM_OFF_REF1_CFG:  q_nxt.rdata = {1'b0, q_r.ref1_cfg};
        `ICM_OFF_REF2_CFG:  q_nxt.rdata = {1'b0, q_r.ref2_cfg};
        `ICM_OFF_REF3_CFG:  q_nxt.rdata = {1'b0, q_r.ref3_cfg};
        `ICM_OFF_STATUS:    q_nxt.rdata = {4'h0, valid_w};
        default:            q_nxt.rdata = `ICM_ZERO8;
      endcase
    end
    // flag the setting that software should not make
    q_nxt.conflict = doubler_enable &&
      (q_nxt.xtal_cfg[`ICM_DIV_HI:`ICM_DIV_LO] == `ICM_DIV_2);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign reg_rdata          = q_r.rdata;
  assign crystal_amp_drive  = q_r.amp;
  assign second_pin_cap_sel = q_r.caps[`ICM_CAP2_HI:`ICM_CAP2_LO];
  assign first_pin_cap_sel  = q_r.caps[`ICM_CAP1_HI:`ICM_CAP1_LO];
  assign monitor_feed       = feed_w;
  assign analog_pll_feed    = pll_w;
  assign input_valid        = valid_w;
  assign prediv_conflict    = q_r.conflict;

  a_amp_write: assert property (
    @(posedge clock) disable iff (!nrst)
    (reg_wr && reg_addr == `ICM_OFF_AMP_DRIVE)
      |=> crystal_amp_drive == $past(reg_wdata))
    else $error("amplifier drive not loaded");
  a_caps_split: assert property (
    @(posedge clock) disable iff (!nrst)
    (reg_wr && reg_addr == `ICM_OFF_PIN_CAPS)
      |=> second_pin_cap_sel == $past(reg_wdata[`ICM_CAP2_HI:`ICM_CAP2_LO]) &&
          first_pin_cap_sel == $past(reg_wdata[`ICM_CAP1_HI:`ICM_CAP1_LO]))
    else $error("pin capacitor nibbles wrong");
  a_xtal_feed_off: assert property (
    @(posedge clock) disable iff (!nrst)
    (reg_wr && reg_addr == `ICM_OFF_XTAL_CFG && reg_wdata[`ICM_BIT_DIS])
      |=> ##1 !monitor_feed[0] && !input_valid[0])
    else $error("crystal still fed to monitor");
  a_xtal_fast_valid: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(input_valid[0]) |-> $past(crystal_input) &&
      !$past(crystal_input, 2) && !$past(q_r.xtal_cfg[`ICM_BIT_DIS]))
    else $error("crystal valid without a rising input edge");
  a_ref_pol_inv: assert property (
    @(posedge clock) disable iff (!nrst)
    (q_r.ref1_cfg[`ICM_BIT_POL] &&
     q_r.ref1_cfg[`ICM_DIV_HI:`ICM_DIV_LO] == `ICM_DIV_1 &&
     $stable(q_r.ref1_cfg))
      |=> analog_pll_feed[1] == !$past(reference_input_1))
    else $error("reference lock edge not inverted");
  a_xtal_pol_pass: assert property (
    @(posedge clock) disable iff (!nrst)
    (!q_r.xtal_cfg[`ICM_BIT_POL] &&
     q_r.xtal_cfg[`ICM_DIV_HI:`ICM_DIV_LO] == `ICM_DIV_1 &&
     $stable(q_r.xtal_cfg))
      |=> analog_pll_feed[0] == $past(crystal_input))
    else $error("crystal feed not following input");
  a_xtal_unused_div: assert property (
    @(posedge clock) disable iff (!nrst)
    (!q_r.xtal_cfg[`ICM_BIT_POL] && q_r.xtal_cfg[`ICM_DIV_HI] &&
     $stable(q_r.xtal_cfg))
      |=> analog_pll_feed[0] == $past(crystal_input))
    else $error("crystal unused divide code not pass-through");
  a_ref_div2: assert property (
    @(posedge clock) disable iff (!nrst)
    ($rose(analog_pll_feed[2]) &&
     q_r.ref2_cfg[`ICM_DIV_HI:`ICM_DIV_LO] == `ICM_DIV_2 &&
     !q_r.ref2_cfg[`ICM_BIT_POL] && $stable(q_r.ref2_cfg))
      |=> !$rose(analog_pll_feed[2]))
    else $error("divide by two toggled twice");
  a_conflict_flag: assert property (
    @(posedge clock) disable iff (!nrst)
    (doubler_enable &&
     q_r.xtal_cfg[`ICM_DIV_HI:`ICM_DIV_LO] == `ICM_DIV_2 && !reg_wr)
      |=> prediv_conflict)
    else $error("conflict not flagged");
  a_unmapped_zero: assert property (
    @(posedge clock) disable iff (!nrst)
    (reg_rd && reg_addr > `ICM_OFF_STATUS) |=> reg_rdata == `ICM_ZERO8)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (
    @(posedge clock) disable iff (!nrst)
    (reg_rd && reg_addr == `ICM_OFF_REF3_CFG) |=> !reg_rdata[7])
    else $error("reserved bit seven not zero");

endmodule // icm_top
`default_nettype wire

/* icm_src_model.sv */
// input clock source model for the crystal and three reference inputs
`timescale 1ns/100ps
`default_nettype none
module icm_src_model (
  input  wire logic       clock,
  input  wire logic [3:0] run,
  output var  logic [3:0] clk_out
);
  logic [3:0] ph = 4'h0;
  initial clk_out = 4'h0;
  // each source has a period of four clocks; a stopped source parks low
  always @(posedge clock)
  begin
    for (int i = 0; i < 4; i++)
    begin
      ph[i]      <= run[i] ? ~ph[i] : 1'b0;
      clk_out[i] <= run[i] ? (clk_out[i] ^ ph[i]) : 1'b0;
    end
  end
endmodule // icm_src_model
`default_nettype wire

/* icm_top_tb.sv */
// self-checking bench for the input clock configuration and monitor block
`timescale 1ns/100ps
`default_nettype none
`include "icm_regs.svh"
module icm_top_tb;
  logic       clock;
  logic       nrst;
  logic [9:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       doubler_enable;
  logic [3:0] run;
  logic [3:0] src;
  logic [7:0] crystal_amp_drive;
  logic [3:0] second_pin_cap_sel;
  logic [3:0] first_pin_cap_sel;
  logic [3:0] monitor_feed;
  logic [3:0] analog_pll_feed;
  logic [3:0] input_valid;
  logic       prediv_conflict;
  logic [3:0] pll_q = 4'h0;
  logic [7:0] rv;
  logic [3:0] seen;
  int         err_total = 0;
  int         compares = 0;
  int         ecnt [4] = '{0, 0, 0, 0};
  int         snap [4];
  int         e;

  icm_src_model i_icm_src_model (.clock(clock), .run(run), .clk_out(src));

  icm_top i_icm_top (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .doubler_enable(doubler_enable), .crystal_input(src[0]),
    .reference_input_1(src[1]), .reference_input_2(src[2]),
    .reference_input_3(src[3]), .crystal_amp_drive(crystal_amp_drive),
    .second_pin_cap_sel(second_pin_cap_sel),
    .first_pin_cap_sel(first_pin_cap_sel), .monitor_feed(monitor_feed),
    .analog_pll_feed(analog_pll_feed), .input_valid(input_valid),
    .prediv_conflict(prediv_conflict));

  // counts rising edges of each divided feed
  always @(posedge clock)
  begin
    pll_q <= analog_pll_feed;
    for (int i = 0; i < 4; i++)
      if (analog_pll_feed[i] && !pll_q[i])
        ecnt[i] <= ecnt[i] + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x,
                     input string m);
    compares++;
    if (s !== x)
    begin
      err_total++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, m, s, x);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    tick(1);
    d = reg_rdata;
  endtask

  task automatic cfg_all(input logic [7:0] d);
    wr(`ICM_OFF_XTAL_CFG, d);
    wr(`ICM_OFF_REF1_CFG, d);
    wr(`ICM_OFF_REF2_CFG, d);
    wr(`ICM_OFF_REF3_CFG, d);
  endtask

  task automatic src_set(input logic [3:0] v);
    @(posedge clock);
    run <= v;
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    err_total++;
    final_report;
  end

  initial
  begin
    nrst = 1'b0;
    reg_addr = 10'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    doubler_enable = 1'b0;
    run = 4'h0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    tick(1);
    chk({crystal_amp_drive, first_pin_cap_sel, input_valid}, 32'h0, "reset");
    for (int a = 0; a < 8; a++)
    begin
      rd(10'h300 + 10'(a), rv);
      chk(rv, 32'h0, "reset value");
    end
    $display("test reset done");
    wr(`ICM_OFF_AMP_DRIVE, 8'h50);
    tick(1);
    chk(crystal_amp_drive, 32'h50, "amp drive output");
    rd(`ICM_OFF_AMP_DRIVE, rv);
    chk(rv, 32'h50, "amp drive readback");
    wr(`ICM_OFF_PIN_CAPS, 8'ha3);
    tick(1);
    chk(second_pin_cap_sel, 32'ha, "second pin cap");
    chk(first_pin_cap_sel, 32'h3, "first pin cap");
    wr(`ICM_OFF_REF2_CFG, 8'hff);
    rd(`ICM_OFF_REF2_CFG, rv);
    chk(rv, 32'h7f, "config readback");
    wr(10'h3ff, 8'h55);
    rd(10'h3ff, rv);
    chk(rv, 32'h0, "unmapped read");
    $display("test registers done");
    cfg_all(8'h40);
    tick(4);
    chk(analog_pll_feed, 32'hf, "falling edge select");
    cfg_all(8'h00);
    tick(4);
    chk(analog_pll_feed, 32'h0, "rising edge select");
    $display("test polarity done");
    cfg_all(8'h20);
    src_set(4'hf);
    seen = 4'h0;
    for (int i = 0; i < 40; i++)
    begin
      tick(1);
      seen = seen | monitor_feed | input_valid;
    end
    chk(seen, 32'h0, "monitor gated off");
    cfg_all(8'h00);
    for (int i = 0; i < 40; i++)
    begin
      tick(1);
      seen = seen | monitor_feed;
    end
    chk(seen, 32'hf, "monitor fed");
    chk(input_valid, 32'hf, "valid with one cycle interval");
    rd(`ICM_OFF_STATUS, rv);
    chk(rv, 32'hf, "status valid bits");
    $display("test monitor feed done");
    for (int c = 1; c < 6; c++)
    begin
      src_set(4'h0);
      tick(80);
      chk(input_valid, 32'h0, "valid drops on missing edges");
      cfg_all(8'(c << 2));
      src_set(4'hf);
      tick(4 * (1 << (2 * c)) - 2);
      chk(input_valid, 32'h0, "valid before interval");
      tick(1);
      chk(input_valid, 32'hf, "valid after interval");
    end
    src_set(4'h0);
    tick(80);
    cfg_all(8'h0c);
    src_set(4'hf);
    tick(160);
    src_set(4'h0);
    tick(80);
    src_set(4'hf);
    tick(160);
    chk(input_valid, 32'h0, "count restarts after gap");
    tick(120);
    chk(input_valid, 32'hf, "valid after full interval");
    $display("test validation done");
    for (int d = 0; d < 4; d++)
    begin
      cfg_all(8'(d) | ((d == 0) ? 8'h40 : 8'h00));
      tick(16);
      snap = ecnt;
      tick(256);
      for (int i = 0; i < 4; i++)
      begin
        e = (i == 0) ? ((d == 1) ? 32 : 64) : (64 >> d);
        chk(ecnt[i] - snap[i] >= e - 1 && ecnt[i] - snap[i] <= e + 1, 32'h1,
            "prediv ratio");
      end
    end
    $display("test prediv done");
    @(posedge clock);
    doubler_enable <= 1'b1;
    wr(`ICM_OFF_XTAL_CFG, 8'h01);
    tick(2);
    chk(prediv_conflict, 32'h1, "doubler with divide by two");
    wr(`ICM_OFF_XTAL_CFG, 8'h00);
    tick(2);
    chk(prediv_conflict, 32'h0, "doubler with divide by one");
    $display("test conflict done");
    final_report;
  end
endmodule // icm_top_tb
`default_nettype wire
